// [include/dest_fetch_pkg.sv]
`default_nettype none
package dest_fetch_pkg;
	localparam int unsigned WORD_WIDTH = 16;
	localparam int unsigned MODE_WIDTH = 3;
	localparam logic [2:0] MODE_DEFERRED = 3'h1;
	localparam logic [2:0] MODE_AUTOINC = 3'h2;
	localparam logic [2:0] MODE_AUTOINC_DEF = 3'h3;
	localparam logic [2:0] MODE_AUTODEC = 3'h4;
	localparam logic [2:0] MODE_AUTODEC_DEF = 3'h5;
	localparam logic [2:0] MODE_INDEX = 3'h6;
	localparam logic [2:0] MODE_INDEX_DEF = 3'h7;
	localparam logic [15:0] STEP_NONE = 16'h0000;
	localparam logic [15:0] STEP_BYTE = 16'h0001;
	localparam logic [15:0] STEP_WORD = 16'h0002;
	localparam int unsigned SWAP_LOW = 8;
	localparam int unsigned SYNC_STAGES = 3;

	typedef enum logic [1:0] {DATI, DATIP, DATO} bus_kind_type;
	typedef enum logic [2:0] {class_other, class_float, class_jump, class_jsr,
		class_copy} insn_class_type;

	typedef struct packed {
		logic active;
		bus_kind_type kind;
		logic [15:0] addr;
		logic [15:0] wdata;
	} bus_req_type;

	function automatic logic [15:0] step_of(input logic [2:0] mode, input logic byte_op);
		logic [15:0] s;
		s = STEP_NONE;
		if (mode == MODE_AUTOINC || mode == MODE_AUTODEC)
			s = byte_op ? STEP_BYTE : STEP_WORD;
		else if (mode == MODE_AUTOINC_DEF || mode == MODE_AUTODEC_DEF)
			s = STEP_WORD;
		return s;
	endfunction

	function automatic logic [15:0] swap_bytes(input logic [15:0] w);
		return {w[SWAP_LOW-1:0], w[WORD_WIDTH-1:SWAP_LOW]};
	endfunction
endpackage
`default_nettype wire

// [verilog/reply_sync.sv]
`default_nettype none
module reply_sync
(
	input wire logic clock,
	input wire logic rst,
	input wire logic async_in,
	output logic sync_out
);
	logic [dest_fetch_pkg::SYNC_STAGES-1:0] stage_reg;

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			stage_reg <= '0;
		else
			stage_reg <= {stage_reg[1:0], async_in};
	end

	// A level counts only once the two later stages agree
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			sync_out <= 1'b0;
		else if (stage_reg[1] == stage_reg[2])
			sync_out <= stage_reg[2];
	end
endmodule // reply_sync
`default_nettype wire

// [verilog/bus_launcher.sv]
`default_nettype none
module bus_launcher
(
	input wire logic clock,
	input wire logic rst,
	input wire logic go,
	input wire logic abort,
	input wire dest_fetch_pkg::bus_req_type req_in,
	input wire logic reply,
	output dest_fetch_pkg::bus_req_type bus_out,
	output logic done
);
	logic armed_reg;

	// A new request waits until the slave has dropped its previous reply
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			bus_out <= '0;
			armed_reg <= 1'b0;
		end
		else if (abort)
		begin
			bus_out.active <= 1'b0;
			armed_reg <= 1'b0;
		end
		else if (go)
		begin
			bus_out <= {1'b0, req_in.kind, req_in.addr, req_in.wdata};
			armed_reg <= 1'b1;
		end
		else if (armed_reg && !reply)
		begin
			bus_out.active <= 1'b1;
			armed_reg <= 1'b0;
		end
		else if (bus_out.active && reply)
			bus_out.active <= 1'b0;
	end

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			done <= 1'b0;
		else
			done <= bus_out.active && reply && !abort;
	end
endmodule // bus_launcher
`default_nettype wire

// [verilog/dest_fetch_sequencer.sv]
// Behaviour
// - Enter modes 1-3 from either dispatch
// - Mode 1-3 sequences begin a bus cycle
// - Inhibit decode bus start for first-dispatch 1-3
// - Move source between bus data and source
// - Mode 3 keeps fetched address in bus data
// - Three-way branch after mode 1/2 start
// - Float aborts transfer, enters float service
// - Jump and subroutine take the transfer
// - Copy class writes, loads codes, fetches next
// - Others read, swap odd byte, dispatch
// - Modes 1/2 step register by 0/1/2
// - Mode 3 steps by two, then indirect
// - Modes 4/5 decrement before use
// - Modes 6/7 use program counter first
// - Only after-source entries may swap source
// - Decrement constant one for mode 4 byte, else two
// - Mode 4 post-decrement state starts instruction's cycle kind
// - Indirect word becomes second transfer address
// - First-dispatch 4/5 aborts decode transfer
// - Modes 6/7 fetch index through program counter
// - Index add, then mode 4 or 5 path
// - Ending fork: write or read, swap, dispatch
`default_nettype none
module dest_fetch_sequencer
(
	input wire logic clock,
	input wire logic rst,
	input wire logic dispatch_first,
	input wire logic dispatch_after,
	input wire logic [2:0] dest_mode,
	input wire logic byte_op,
	input wire logic read_modify,
	input wire logic swap_source,
	input wire dest_fetch_pkg::insn_class_type insn_class,
	input wire logic [15:0] dest_reg_value,
	input wire logic [15:0] pc_value,
	input wire logic [15:0] source_value,
	input wire logic [15:0] src_word,
	input wire logic bus_reply,
	input wire logic [15:0] bus_rdata,
	output dest_fetch_pkg::bus_req_type bus_req,
	output logic bus_cycle_end,
	output logic decode_start_inhibit,
	output logic [15:0] bus_data_reg,
	output logic [15:0] source_operand_reg,
	output logic [15:0] destination_copy_reg,
	output logic dest_reg_write,
	output logic [15:0] dest_reg_new,
	output logic pc_write,
	output logic [15:0] pc_new,
	output logic op_dispatch,
	output logic float_entry,
	output logic jump_go,
	output logic jsr_go,
	output logic cc_load,
	output logic fetch_next,
	output logic busy
);
	typedef enum logic [3:0] {idle_st, start123_st, first_wait_st, second_start_st,
		dec45_st, start45_st, pc_start_st, index_wait_st, index_add_st, end_fork_st,
		write_wait_st, read_wait_st, swap_st} state_type;

	state_type state_reg;
	logic [2:0] mode_reg;
	logic byte_reg;
	logic rmw_reg;
	logic first_reg;
	logic indirect_reg;
	dest_fetch_pkg::insn_class_type class_reg;
	logic reply_synced;
	logic xfer_done;
	logic launch_go;
	logic launch_abort;
	dest_fetch_pkg::bus_req_type launch_req;
	logic [15:0] step;
	logic entering;

	assign entering = (dispatch_first || dispatch_after) && state_reg == idle_st
		&& dest_mode != 3'h0;
	assign decode_start_inhibit = dispatch_first && dest_mode >= dest_fetch_pkg::MODE_DEFERRED
		&& dest_mode <= dest_fetch_pkg::MODE_AUTOINC_DEF;
	assign step = dest_fetch_pkg::step_of(mode_reg, byte_reg);
	assign busy = state_reg != idle_st;

	// Launch requests; the first word of an indirect mode is always a read
	always_comb
	begin
		launch_go = 1'b0;
		launch_req = '0;
		launch_req.wdata = bus_data_reg;
		launch_req.addr = destination_copy_reg;
		launch_req.kind = dest_fetch_pkg::DATI;
		if (class_reg == dest_fetch_pkg::class_copy)
			launch_req.kind = dest_fetch_pkg::DATO;
		else if (rmw_reg)
			launch_req.kind = dest_fetch_pkg::DATIP;
		unique case (state_reg)
			start123_st:
			begin
				launch_go = 1'b1;
				if (mode_reg == dest_fetch_pkg::MODE_AUTOINC_DEF)
					launch_req.kind = dest_fetch_pkg::DATI;
			end
			start45_st:
			begin
				launch_go = 1'b1;
				if (indirect_reg)
					launch_req.kind = dest_fetch_pkg::DATI;
			end
			second_start_st:
			begin
				launch_go = 1'b1;
				launch_req.addr = bus_data_reg;
			end
			pc_start_st:
			begin
				launch_go = 1'b1;
				launch_req.kind = dest_fetch_pkg::DATI;
				launch_req.addr = pc_value;
			end
			default:
				launch_go = 1'b0;
		endcase
	end

	assign launch_abort = (state_reg == end_fork_st && class_reg == dest_fetch_pkg::class_float)
		|| (state_reg == dec45_st && first_reg);

	reply_sync reply_sync_inst
	(
		.clock(clock),
		.rst(rst),
		.async_in(bus_reply),
		.sync_out(reply_synced)
	);

	bus_launcher bus_launcher_inst
	(
		.clock(clock),
		.rst(rst),
		.go(launch_go),
		.abort(launch_abort),
		.req_in(launch_req),
		.reply(reply_synced),
		.bus_out(bus_req),
		.done(xfer_done)
	);

	// Sequencing; a wait state holds until the slave has answered
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			state_reg <= idle_st;
		else
			unique case (state_reg)
				idle_st:
					if (entering)
					begin
						if (dest_mode <= dest_fetch_pkg::MODE_AUTOINC_DEF)
							state_reg <= start123_st;
						else if (dest_mode <= dest_fetch_pkg::MODE_AUTODEC_DEF)
							state_reg <= dec45_st;
						else
							state_reg <= pc_start_st;
					end
				start123_st:
					state_reg <= (mode_reg == dest_fetch_pkg::MODE_AUTOINC_DEF) ?
						first_wait_st : end_fork_st;
				dec45_st:
					state_reg <= start45_st;
				start45_st:
					state_reg <= indirect_reg ? first_wait_st : end_fork_st;
				pc_start_st:
					state_reg <= index_wait_st;
				index_wait_st:
					if (xfer_done)
						state_reg <= index_add_st;
				index_add_st:
					state_reg <= start45_st;
				first_wait_st:
					if (xfer_done)
						state_reg <= second_start_st;
				second_start_st:
					state_reg <= end_fork_st;
				end_fork_st:
					if (class_reg == dest_fetch_pkg::class_copy)
						state_reg <= write_wait_st;
					else if (class_reg == dest_fetch_pkg::class_other)
						state_reg <= read_wait_st;
					else
						state_reg <= idle_st;
				write_wait_st:
					if (xfer_done)
						state_reg <= idle_st;
				read_wait_st:
					if (xfer_done)
						state_reg <= (byte_reg && destination_copy_reg[0]) ?
							swap_st : idle_st;
				swap_st:
					state_reg <= idle_st;
			endcase
	end

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			mode_reg <= 3'h0;
			byte_reg <= 1'b0;
			rmw_reg <= 1'b0;
			first_reg <= 1'b0;
			indirect_reg <= 1'b0;
			class_reg <= dest_fetch_pkg::class_other;
		end
		else if (entering)
		begin
			mode_reg <= dest_mode;
			byte_reg <= byte_op;
			rmw_reg <= read_modify;
			first_reg <= dispatch_first;
			class_reg <= insn_class;
			indirect_reg <= dest_mode == dest_fetch_pkg::MODE_AUTODEC_DEF
				|| dest_mode == dest_fetch_pkg::MODE_INDEX_DEF;
		end
		else if (state_reg == index_add_st)
			indirect_reg <= mode_reg == dest_fetch_pkg::MODE_INDEX_DEF;
	end

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			source_operand_reg <= '0;
		else if (entering && dispatch_after)
			source_operand_reg <= src_word;
	end

	// Source swap only on after-source entries: a register source has no high byte
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			bus_data_reg <= '0;
		else if (entering && dispatch_after)
			bus_data_reg <= swap_source ? dest_fetch_pkg::swap_bytes(src_word) : src_word;
		else if (entering && dest_mode != dest_fetch_pkg::MODE_AUTOINC_DEF)
			bus_data_reg <= source_value;
		// Taken with the reply itself: the slave may drop its data once the request falls
		else if (bus_req.active && reply_synced && (state_reg == first_wait_st
			|| state_reg == index_wait_st || state_reg == read_wait_st))
			bus_data_reg <= bus_rdata;
		else if (state_reg == swap_st)
			bus_data_reg <= dest_fetch_pkg::swap_bytes(bus_data_reg);
	end

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			destination_copy_reg <= '0;
		else if (entering)
			destination_copy_reg <= dest_reg_value;
		else if (state_reg == dec45_st)
			destination_copy_reg <= destination_copy_reg - step;
		else if (state_reg == index_add_st)
			destination_copy_reg <= destination_copy_reg + bus_data_reg;
		else if (state_reg == second_start_st)
			destination_copy_reg <= bus_data_reg;
	end

	// General register write-back; mode 3 always steps a full word
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			dest_reg_write <= 1'b0;
			dest_reg_new <= '0;
		end
		else
		begin
			dest_reg_write <= 1'b0;
			if (state_reg == start123_st && mode_reg != dest_fetch_pkg::MODE_AUTOINC_DEF)
			begin
				dest_reg_write <= 1'b1;
				dest_reg_new <= destination_copy_reg + step;
			end
			else if (state_reg == first_wait_st && xfer_done
				&& mode_reg == dest_fetch_pkg::MODE_AUTOINC_DEF)
			begin
				dest_reg_write <= 1'b1;
				dest_reg_new <= destination_copy_reg + dest_fetch_pkg::STEP_WORD;
			end
			else if (state_reg == dec45_st)
			begin
				dest_reg_write <= 1'b1;
				dest_reg_new <= destination_copy_reg - step;
			end
		end
	end

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			pc_write <= 1'b0;
			pc_new <= '0;
			bus_cycle_end <= 1'b0;
			float_entry <= 1'b0;
			jump_go <= 1'b0;
			jsr_go <= 1'b0;
			cc_load <= 1'b0;
			fetch_next <= 1'b0;
			op_dispatch <= 1'b0;
		end
		else
		begin
			pc_write <= state_reg == pc_start_st && !first_reg;
			if (state_reg == pc_start_st)
				pc_new <= pc_value + dest_fetch_pkg::STEP_WORD;
			bus_cycle_end <= launch_abort;
			float_entry <= state_reg == end_fork_st && class_reg == dest_fetch_pkg::class_float;
			jump_go <= state_reg == end_fork_st && class_reg == dest_fetch_pkg::class_jump;
			jsr_go <= state_reg == end_fork_st && class_reg == dest_fetch_pkg::class_jsr;
			cc_load <= state_reg == write_wait_st && xfer_done;
			fetch_next <= state_reg == write_wait_st && xfer_done;
			op_dispatch <= state_reg == swap_st || (state_reg == read_wait_st && xfer_done
				&& !(byte_reg && destination_copy_reg[0]));
		end
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	entry_start_a: assert property (entering && dest_mode <= 3'h3 |=> launch_go)
		else $error("mode 1-3 entry did not start a bus cycle");
	inhibit_a: assert property (dispatch_after |-> !decode_start_inhibit)
		else $error("decode start inhibited on after-source entry");
	copy_write_a: assert property (state_reg == end_fork_st
		&& class_reg == dest_fetch_pkg::class_copy |-> bus_req.kind == dest_fetch_pkg::DATO)
		else $error("copy class final cycle is not a write");
	float_abort_a: assert property (state_reg == end_fork_st
		&& class_reg == dest_fetch_pkg::class_float |=> bus_cycle_end && float_entry
		&& !bus_req.active)
		else $error("float did not abort and enter service");
	mode3_step_a: assert property (state_reg == first_wait_st && xfer_done
		&& mode_reg == 3'h3 |=> dest_reg_write
		&& dest_reg_new == $past(destination_copy_reg) + 16'h0002)
		else $error("mode 3 step is not two");
	predec_a: assert property (state_reg == dec45_st |=> destination_copy_reg
		== $past(destination_copy_reg) - $past(step) && dest_reg_write)
		else $error("predecrement wrong");
	abort_first_a: assert property (state_reg == dec45_st && first_reg |=> bus_cycle_end)
		else $error("first dispatch 4/5 did not abort");
	index_add_a: assert property (state_reg == index_add_st |=> destination_copy_reg
		== $past(destination_copy_reg) + $past(bus_data_reg))
		else $error("index add wrong");
	swap_dispatch_a: assert property (state_reg == read_wait_st && xfer_done && byte_reg
		&& destination_copy_reg[0] |=> !op_dispatch ##1 op_dispatch)
		else $error("odd byte not swapped before dispatch");
	write_end_a: assert property (state_reg == write_wait_st && xfer_done
		|=> cc_load && fetch_next)
		else $error("copy end missing code load or fetch");

	copy_end_c: cover property (cc_load);
	swap_end_c: cover property (state_reg == swap_st);
	float_c: cover property (float_entry);
	index_def_c: cover property (state_reg == index_add_st && mode_reg == 3'h7);
endmodule // dest_fetch_sequencer
`default_nettype wire

// [bench/bus_slave.sv]
`default_nettype none
module bus_slave
(
	input wire logic clock,
	input wire logic rst,
	input wire dest_fetch_pkg::bus_req_type req,
	output logic reply,
	output logic [15:0] rdata
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [15:0] last;
	int n;
	initial
	begin
		reply = 1'b0;
		rdata = 16'h0000;
		last = 16'h0000;
	end
	// Delay taken from address bits gives prompt and slow replies alike
	always
	begin
		@(posedge clock);
		#3;
		if (!rst && req.active)
		begin
			n = 0;
			while (req.active && n < int'(req.addr[2:1]))
			begin
				@(posedge clock);
				#3;
				n++;
			end
			if (req.active)
			begin
				last = (req.addr ^ 16'h3c3c) & 16'hfffe;
				rdata = last;
				reply = 1'b1;
				n = 0;
				while (req.active && n < 50)
				begin
					@(posedge clock);
					#3;
					n++;
				end
				// Released data must not look valid
				reply = 1'b0;
				rdata = ~last;
			end
		end
	end
endmodule // bus_slave
`default_nettype wire

// [bench/testbench.sv]
`default_nettype none
`define check(nm, e, g) begin comparisons++; if ((e) !== (g)) begin n_fail++; \
	$display("unexpected %s expected %h seen %h", nm, e, g); end end
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic dispatch_first = 1'b0;
	logic dispatch_after = 1'b0;
	logic [2:0] dest_mode = 3'h0;
	logic byte_op = 1'b0;
	logic read_modify = 1'b0;
	logic swap_source = 1'b0;
	dest_fetch_pkg::insn_class_type insn_class = dest_fetch_pkg::class_other;
	logic [15:0] dest_reg_value = 16'h0000;
	logic [15:0] pc_value = 16'h0000;
	logic [15:0] source_value = 16'h0000;
	logic [15:0] src_word = 16'h0000;
	logic bus_reply;
	logic [15:0] bus_rdata;
	dest_fetch_pkg::bus_req_type bus_req;
	logic bus_cycle_end, decode_start_inhibit, dest_reg_write, pc_write, busy;
	logic op_dispatch, float_entry, jump_go, jsr_go, cc_load, fetch_next;
	logic [15:0] bus_data_reg, source_operand_reg, dest_reg_new, pc_new, destination_copy_reg;
	int n_fail = 0;
	int comparisons = 0;
	int cycles = 0;
	int seed = 38;
	logic prev_act = 1'b0;
	logic [5:0] seen;
	logic dw_seen, pw_seen, end_seen;
	logic [15:0] dw_val, pw_val;
	logic [15:0] q_addr[$];
	logic [15:0] q_wd[$];
	dest_fetch_pkg::bus_kind_type q_kind[$];

	dest_fetch_sequencer i_dest_fetch_sequencer (.clock(clock), .rst(rst),
		.dispatch_first(dispatch_first), .dispatch_after(dispatch_after),
		.dest_mode(dest_mode), .byte_op(byte_op), .read_modify(read_modify),
		.swap_source(swap_source), .insn_class(insn_class), .dest_reg_value(dest_reg_value),
		.pc_value(pc_value), .source_value(source_value), .src_word(src_word),
		.bus_reply(bus_reply), .bus_rdata(bus_rdata), .bus_req(bus_req),
		.bus_cycle_end(bus_cycle_end), .decode_start_inhibit(decode_start_inhibit),
		.bus_data_reg(bus_data_reg), .source_operand_reg(source_operand_reg),
		.destination_copy_reg(destination_copy_reg), .dest_reg_write(dest_reg_write),
		.dest_reg_new(dest_reg_new),
		.pc_write(pc_write), .pc_new(pc_new), .op_dispatch(op_dispatch),
		.float_entry(float_entry), .jump_go(jump_go), .jsr_go(jsr_go), .cc_load(cc_load),
		.fetch_next(fetch_next), .busy(busy));
	bus_slave i_bus_slave (.clock(clock), .rst(rst), .req(bus_req), .reply(bus_reply),
		.rdata(bus_rdata));

	always #50 clock = ~clock;

	function automatic logic [15:0] rd(input logic [15:0] a);
		return (a ^ 16'h3c3c) & 16'hfffe;
	endfunction
	function automatic logic [15:0] swp(input logic [15:0] w);
		return {w[7:0], w[15:8]};
	endfunction
	function automatic logic [15:0] stp(input logic [2:0] m, input logic b);
		return (m == 3'h1 || m > 3'h5) ? 16'h0000 : ((b && (m == 3'h2 || m == 3'h4)) ? 16'h0001 : 16'h0002);
	endfunction

	// Registered outputs are read before this edge's updates land
	always @(posedge clock)
	begin
		if (bus_req.active && !prev_act)
		begin
			q_addr.push_back(bus_req.addr);
			q_kind.push_back(bus_req.kind);
			q_wd.push_back(bus_req.wdata);
		end
		prev_act = bus_req.active;
		seen = seen | {float_entry, jump_go, jsr_go, cc_load, fetch_next, op_dispatch};
		if (dest_reg_write)
			dw_val = dest_reg_new;
		if (pc_write)
			pw_val = pc_new;
		pw_seen = pw_seen | pc_write;
		dw_seen = dw_seen | dest_reg_write;
		end_seen = end_seen | bus_cycle_end;
	end

	task automatic close_out;
		$display("comparisons %0d n_fail %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	always @(posedge clock)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			n_fail++;
			close_out();
		end
	end

	task automatic run_op(input logic f, input logic [2:0] m, input dest_fetch_pkg::insn_class_type c);
		logic [15:0] d, p, st, la, ew;
		logic [15:0] e[$];
		logic [5:0] xf;
		int w;
		int q;
		d = 16'($random(seed));
		p = 16'($random(seed)) & 16'hfffe;
		byte_op = 1'($random(seed));
		if (!byte_op)
			d[0] = 1'b0;
		st = stp(m, byte_op);
		case (m)
			3'h1, 3'h2: e = {d};
			3'h3: e = {d, rd(d)};
			3'h4: e = {d - st};
			3'h5: e = {d - st, rd(d - st)};
			3'h6: e = {p, rd(p) + d};
			default: e = {p, rd(p) + d, rd(rd(p) + d)};
		endcase
		case (c)
			dest_fetch_pkg::class_float: xf = 6'h20;
			dest_fetch_pkg::class_jump: xf = 6'h10;
			dest_fetch_pkg::class_jsr: xf = 6'h08;
			dest_fetch_pkg::class_copy: xf = 6'h06;
			default: xf = 6'h01;
		endcase
		@(posedge clock);
		#2;
		q_addr = {};
		q_kind = {};
		q_wd = {};
		seen = 6'h00;
		pw_seen = 1'b0;
		dw_seen = 1'b0;
		end_seen = 1'b0;
		dw_val = 16'hxxxx;
		dest_mode = m;
		insn_class = c;
		dest_reg_value = d;
		pc_value = p;
		source_value = 16'($random(seed));
		src_word = 16'($random(seed));
		read_modify = 1'($random(seed));
		swap_source = 1'($random(seed));
		dispatch_first = f;
		dispatch_after = !f;
		#1;
		`check("inhibit", f && m < 3'h4, decode_start_inhibit)
		@(posedge clock);
		#2;
		dispatch_first = 1'b0;
		dispatch_after = 1'b0;
		w = 0;
		q = 0;
		// A jump leaves its transfer pending: wait until the bus has stayed quiet
		while (q < 8 && w < 300)
		begin
			@(posedge clock);
			#2;
			w++;
			q = (busy === 1'b0 && bus_req.active === 1'b0 && bus_reply === 1'b0) ? q + 1 : 0;
		end
		`check("exit", xf, seen)
		`check("last addr", e[e.size() - 1], destination_copy_reg)
		`check("regwrite", m < 3'h6, dw_seen)
		// A float aborts its last transfer before the request is raised
		if (c == dest_fetch_pkg::class_float)
			void'(e.pop_back());
		`check("count", 32'(e.size()), 32'(q_addr.size()))
		for (int i = 0; i < e.size() && i < q_addr.size(); i++)
			`check("addr", e[i], q_addr[i])
		if (m > 3'h1 && m < 3'h6)
			`check("regstep", (m < 3'h4) ? d + st : d - st, dw_val)
		if (m > 3'h5)
			`check("pcstep", !f, pw_seen)
		if (!f && m > 3'h5)
			`check("pcnew", p + 16'h0002, pw_val)
		if (c == dest_fetch_pkg::class_float || (f && (m == 3'h4 || m == 3'h5)))
			`check("abort", 1'b1, end_seen)
		if (!f)
			`check("source", src_word, source_operand_reg)
		if (q_kind.size() == 0)
			return;
		la = q_addr[q_addr.size() - 1];
		if (c == dest_fetch_pkg::class_copy)
		begin
			`check("wkind", dest_fetch_pkg::DATO, q_kind[q_kind.size() - 1])
			ew = f ? source_value : (swap_source ? swp(src_word) : src_word);
			if (m < 3'h3)
				`check("wdata", ew, q_wd[q_wd.size() - 1])
		end
		if (c == dest_fetch_pkg::class_other)
		begin
			ew = (byte_op && la[0]) ? swp(rd(la)) : rd(la);
			`check("rkind", read_modify ? dest_fetch_pkg::DATIP : dest_fetch_pkg::DATI,
				q_kind[q_kind.size() - 1])
			`check("rdata", ew, bus_data_reg)
		end
	endtask

	initial
	begin
		repeat (6) @(posedge clock);
		#2;
		rst = 1'b0;
		dispatch_after = 1'b1;
		@(posedge clock);
		#2;
		dispatch_after = 1'b0;
		@(posedge clock);
		#2;
		`check("refused", 1'b0, busy)
		for (int m = 1; m < 8; m++)
			for (int c = 0; c < 5; c++)
				for (int f = 0; f < 2; f++)
					run_op(1'(f), 3'(m), dest_fetch_pkg::insn_class_type'(3'(c)));
		close_out();
	end
endmodule // testbench
`default_nettype wire
